// file: rtl/tpes_pkg.sv
// constants for the trigger path energy sum block
// assumes one 100 MHz sample clock and an apb3 master for configuration
package tpes_pkg;
  localparam int NCH       = 16;
  localparam int SW        = 12;
  localparam int SUMW      = 16;
  localparam int DLY_DEPTH = 16;
  localparam int BEF_W     = 4;
  localparam int AFT_W     = 6;
  localparam int CNT_W     = 7;
  localparam int TS_W      = 32;
  // register byte offsets and the pedestal page number
  localparam logic [7:0] OFF_CFG1   = 8'h00;
  localparam logic [7:0] OFF_CFG3   = 8'h08;
  localparam logic [7:0] OFF_WIN    = 8'h0c;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [7:0] OFF_TSTAMP = 8'h18;
  localparam logic [1:0] PED_PAGE   = 2'h1;
  // field positions
  localparam int CH_SEL_LSB   = 8;
  localparam int CH_SEL_MSB   = 11;
  localparam int THR_MSB      = 11;
  localparam int SYNC_DIS_BIT = 15;
  localparam int BEF_LSB      = 0;
  localparam int BEF_MSB      = 3;
  localparam int AFT_LSB      = 8;
  localparam int AFT_MSB      = 13;
  localparam int SOFT_BIT     = 0;
  localparam int SYNC_BIT     = 1;
  localparam int CONV_BIT     = 2;
  // reset values and the counter increment
  localparam logic [31:0]      CFG_RST = 32'h0000_0000;
  localparam logic [SW-1:0]    PED_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
endpackage

// file: rtl/tpes_energy_sum.sv
// trigger path sample gating and sixteen channel energy summer
// assumes samples arrive on pins asynchronous in phase to pclk, apb3 master
`timescale 1ns/1ns
`default_nettype none
module tpes_energy_sum
  import tpes_pkg::*;
(
  // clock and hard reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // converter streams, channel n in bits 12n+11..12n
  input  wire logic [NCH*SW-1:0]   adc_data,
  input  wire logic                sync_in,
  // results
  output var  logic [SUMW-1:0]     energy_sum,
  output var  logic [NCH-1:0]      channel_hit_flag,
  output var  logic                converter_reset
);

  logic [31:0]      cfg1;
  logic [31:0]      third_config_reg;
  logic [31:0]      win_cfg;
  logic [SW-1:0]    ped [NCH];
  logic [TS_W-1:0]  tstamp;
  logic             soft_rst;
  logic             sync_sw;
  logic             sync_p1;
  logic             sync_p2;
  logic             sync_lvl;
  logic [SW-1:0]    s1 [NCH];
  logic [SW-1:0]    s2 [NCH];
  logic [SW-1:0]    inq [NCH];
  logic [SW-1:0]    sr [NCH][DLY_DEPTH];
  logic [SW-1:0]    sub [NCH];
  logic [SW-1:0]    contrib [NCH];
  logic             above [NCH];
  logic             above_q [NCH];
  logic             active [NCH];
  logic [CNT_W-1:0] cnt [NCH];
  logic [CNT_W-1:0] lim [NCH];
  logic [SUMW-1:0]  sum_acc;
  logic [31:0]      rd_mux;
  logic             rd_hit;
  logic [SW-1:0]    thr;
  logic [BEF_W-1:0] bef;
  logic [AFT_W-1:0] aft;
  logic [7:0]       addr;
  logic             acc;
  logic             wr_en;
  logic             ped_sel;
  logic [3:0]       ped_idx;
  logic [3:0]       ch_sel;

  assign thr     = third_config_reg[THR_MSB:0];
  assign bef     = win_cfg[BEF_MSB:BEF_LSB];
  assign aft     = win_cfg[AFT_MSB:AFT_LSB];
  assign ch_sel  = cfg1[CH_SEL_MSB:CH_SEL_LSB];
  assign addr    = paddr[7:0];
  assign acc     = psel & penable;
  assign wr_en   = acc & pready & pwrite;
  assign ped_sel = (addr[7:6] == PED_PAGE);
  assign ped_idx = addr[5:2];

  // apb: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= acc & ~pready;
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (ped_sel)
      rd_mux = {20'h00000, ped[ped_idx]};
    else
    begin
      case (addr)
        OFF_CFG1:   rd_mux = cfg1;
        OFF_CFG3:   rd_mux = third_config_reg;
        OFF_WIN:    rd_mux = win_cfg;
        OFF_CTRL:   rd_mux = {29'h0, converter_reset, 2'h0};
        OFF_STAT:   rd_mux = {20'h00000, inq[ch_sel]};
        OFF_TSTAMP: rd_mux = tstamp;
        default:    rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (acc & ~pready)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

  // configuration cleared by hard reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg1             <= CFG_RST;
      third_config_reg <= CFG_RST;
      win_cfg          <= CFG_RST;
      converter_reset  <= 1'b0;
    end
    else if (wr_en)
    begin
      if (addr == OFF_CFG1)
        cfg1 <= pwdata;
      if (addr == OFF_CFG3)
        third_config_reg <= pwdata;
      if (addr == OFF_WIN)
        win_cfg <= pwdata;
      if (addr == OFF_CTRL)
        converter_reset <= pwdata[CONV_BIT];
    end
  end

  // soft reset and software sync pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_rst <= 1'b0;
      sync_sw  <= 1'b0;
    end
    else
    begin
      soft_rst <= wr_en & (addr == OFF_CTRL) & pwdata[SOFT_BIT];
      sync_sw  <= wr_en & (addr == OFF_CTRL) & pwdata[SYNC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_p1 <= 1'b0;
      sync_p2 <= 1'b0;
    end
    else
    begin
      sync_p1 <= sync_in;
      sync_p2 <= sync_p1;
    end
  end

  assign sync_lvl = sync_p2 | sync_sw;

  // time stamp cleared by sync alone
  always_ff @(posedge pclk)
  begin
    if (sync_lvl)
      tstamp <= '0;
    else
      tstamp <= tstamp + 32'h0000_0001;
  end

  always_comb
  begin
    sum_acc = '0;
    for (int k = 0; k < NCH; k++)
      sum_acc = sum_acc + {4'h0, contrib[k]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      energy_sum <= '0;
    else if (soft_rst)
      energy_sum <= '0;
    else
      energy_sum <= sum_acc;
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [SW:0]      diff;
    logic             new_pulse;
    logic [CNT_W-1:0] cnt_inc;

    // pedestal subtraction, negative clamps to zero
    assign diff      = {1'b0, sr[i][bef]} - {1'b0, ped[i]};
    assign sub[i]    = diff[SW] ? PED_RST : diff[SW-1:0];
    assign above[i]  = (s2[i] >= thr);
    assign new_pulse = above[i] & ~above_q[i];
    assign cnt_inc   = cnt[i] + CNT_ONE;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ped[i] <= PED_RST;
      else if (wr_en && ped_sel && ped_idx == i)
        ped[i] <= pwdata[SW-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1[i] <= '0;
        s2[i] <= '0;
      end
      else
      begin
        s1[i] <= adc_data[i*SW +: SW];
        s2[i] <= s1[i];
      end
    end

    // sync clears input stage unless disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        inq[i] <= '0;
      else if (soft_rst || (sync_lvl && !third_config_reg[SYNC_DIS_BIT]))
        inq[i] <= '0;
      else
        inq[i] <= s2[i];
    end

    // delay line tapped at before setting
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        for (int d = 0; d < DLY_DEPTH; d++)
          sr[i][d] <= '0;
      end
      else if (soft_rst)
      begin
        for (int d = 0; d < DLY_DEPTH; d++)
          sr[i][d] <= '0;
      end
      else
      begin
        sr[i][0] <= inq[i];
        for (int d = 1; d < DLY_DEPTH; d++)
          sr[i][d] <= sr[i][d-1];
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        active[i]  <= 1'b0;
        cnt[i]     <= '0;
        lim[i]     <= '0;
        above_q[i] <= 1'b0;
      end
      else if (soft_rst)
      begin
        active[i]  <= 1'b0;
        cnt[i]     <= '0;
        lim[i]     <= '0;
        above_q[i] <= 1'b0;
      end
      else
      begin
        above_q[i] <= above[i];
        if (!active[i])
        begin
          // first window before plus after plus one
          if (above[i])
          begin
            active[i] <= 1'b1;
            cnt[i]    <= '0;
            lim[i]    <= {3'h0, bef} + {1'b0, aft} + CNT_ONE;
          end
        end
        else if (new_pulse)
        begin
          cnt[i] <= '0;
          lim[i] <= {1'b0, aft};
        end
        else if (cnt_inc >= lim[i])
        begin
          // repeat while last emitted sample above
          if (sr[i][bef] >= thr)
          begin
            cnt[i] <= '0;
            lim[i] <= {1'b0, aft};
          end
          else
            active[i] <= 1'b0;
        end
        else
          cnt[i] <= cnt_inc;
      end
    end

    // registered gate adds the extra sample
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        contrib[i]          <= '0;
        channel_hit_flag[i] <= 1'b0;
      end
      else if (soft_rst)
      begin
        contrib[i]          <= '0;
        channel_hit_flag[i] <= 1'b0;
      end
      else
      begin
        contrib[i]          <= active[i] ? sub[i] : PED_RST;
        channel_hit_flag[i] <= (sub[i] >= thr);
      end
    end

    property p_gate_zero;
      @(posedge pclk) disable iff (!presetn)
      !active[i] && !soft_rst |=> contrib[i] == 0;
    endproperty
    a_gate_zero: assert property (p_gate_zero) else $error("idle channel fed nonzero");

    property p_gate_pass;
      @(posedge pclk) disable iff (!presetn)
      active[i] && !soft_rst |=> contrib[i] == $past(sub[i]);
    endproperty
    a_gate_pass: assert property (p_gate_pass) else $error("active channel sample lost");

    property p_start;
      @(posedge pclk) disable iff (!presetn)
      !active[i] && above[i] && !soft_rst
        |=> active[i] && cnt[i] == 0 && lim[i] == $past(bef) + $past(aft) + CNT_ONE;
    endproperty
    a_start: assert property (p_start) else $error("window start wrong");

    property p_restart;
      @(posedge pclk) disable iff (!presetn)
      active[i] && new_pulse && !soft_rst |=> active[i] && cnt[i] == 0 && lim[i] == $past(aft);
    endproperty
    a_restart: assert property (p_restart) else $error("new pulse did not restart");

    property p_repeat;
      @(posedge pclk) disable iff (!presetn)
      active[i] && !new_pulse && cnt_inc >= lim[i] && (sr[i][bef] >= thr) && !soft_rst |=> active[i] && cnt[i] == 0;
    endproperty
    a_repeat: assert property (p_repeat) else $error("count not repeated");

    property p_end;
      @(posedge pclk) disable iff (!presetn)
      active[i] && !new_pulse && cnt_inc >= lim[i] && !(sr[i][bef] >= thr) && !soft_rst
        |=> !active[i] ##1 contrib[i] == 0;
    endproperty
    a_end: assert property (p_end) else $error("gate did not close");

    property p_hit;
      @(posedge pclk) disable iff (!presetn)
      !soft_rst |=> channel_hit_flag[i] == ($past(sub[i]) >= $past(thr));
    endproperty
    a_hit: assert property (p_hit) else $error("hit flag mismatch");

    property p_sync_dis;
      @(posedge pclk) disable iff (!presetn)
      sync_lvl && third_config_reg[SYNC_DIS_BIT] && !soft_rst |=> inq[i] == $past(s2[i]);
    endproperty
    a_sync_dis: assert property (p_sync_dis) else $error("sync cleared input despite disable");
  end

  property p_sum_idle;
    @(posedge pclk) disable iff (!presetn)
    sum_acc == 0 |=> energy_sum == 0;
  endproperty
  a_sum_idle: assert property (p_sum_idle) else $error("sum nonzero while idle");

  property p_tstamp;
    @(posedge pclk) disable iff (!presetn)
    sync_lvl ##1 !sync_lvl |=> tstamp == 1;
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("time stamp not cleared by sync");

endmodule
`default_nettype wire

// file: testbench/tpes_sum_sink.sv
// collector standing in for the control side that forwards energy sums
// assumes one sum per pclk; clr from the bench starts a fresh tally
`timescale 1ns/1ns
`default_nettype none
module tpes_sum_sink
  import tpes_pkg::*;
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // sum stream and hit flags
  input  wire logic [SUMW-1:0] energy_sum,
  input  wire logic [NCH-1:0]  channel_hit_flag,
  input  wire logic            clr,
  // tallies
  output var  logic [31:0]     total,
  output var  logic [31:0]     nz,
  output var  logic [31:0]     hits
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      total <= 32'h0;
      nz    <= 32'h0;
      hits  <= 32'h0;
    end
    else if (clr)
    begin
      total <= 32'h0;
      nz    <= 32'h0;
      hits  <= 32'h0;
    end
    else
    begin
      total <= total + 32'(energy_sum);
      nz    <= nz + 32'(energy_sum != '0);
      hits  <= hits + 32'($countones(channel_hit_flag));
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_tpes_energy_sum.sv
// bench for the energy sum block: apb configuration, pulses, resets, sync
// assumes tpes_sum_sink as the far side and a 100 MHz pclk
`timescale 1ns/1ns
`default_nettype none
module tb_tpes_energy_sum
  import tpes_pkg::*;
;
  localparam logic [3:0]  BEF  = 4'h1;
  localparam logic [5:0]  AFT  = 6'h3;
  localparam logic [11:0] THR  = 12'h180;
  localparam logic [11:0] PED  = 12'h100;
  localparam logic [11:0] BASE = 12'h101;
  localparam logic [11:0] SPK  = 12'h300;
  localparam logic [31:0] WIN  = {18'h0, AFT, 4'h0, BEF};
  localparam logic [31:0] CFG3 = {16'h0, 1'b1, 3'h0, THR};
  logic              pclk, presetn, psel, penable, pwrite, clr, sync_in;
  logic              pready, pslverr, converter_reset, err;
  logic [31:0]       paddr, pwdata, prdata, total, nz, hits, rd;
  logic [NCH*SW-1:0] adc_data;
  logic [SUMW-1:0]   energy_sum;
  logic [NCH-1:0]    channel_hit_flag;
  int                fails, cmp_count;

  tpes_energy_sum i_tpes_energy_sum (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adc_data, .sync_in, .energy_sum, .channel_hit_flag, .converter_reset);
  tpes_sum_sink i_tpes_sum_sink (.pclk, .presetn, .energy_sum, .channel_hit_flag, .clr,
    .total, .nz, .hits);

  always #5 pclk = ~pclk;

  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input bit at_least);
    cmp_count++;
    if (at_least ? ((got >= exp) !== 1'b1) : (got !== exp))
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the request stands until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge pclk);
      i++;
    end
    if (i == 20)
    begin
      fails++;
      $display("mismatch at %0t: no pready", $time);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, 1'b0);
    chk({31'h0, err}, {31'h0, eerr}, 1'b0);
  endtask

  task automatic drive(input logic [NCH-1:0] m, input logic [SW-1:0] v, input int n);
    logic [NCH*SW-1:0] s;
    for (int c = 0; c < NCH; c++)
      s[c*SW +: SW] = m[c] ? v : PED;
    repeat (n)
    begin
      @(posedge pclk);
      adc_data <= s;
    end
  endtask

  task automatic pulse(input logic [NCH-1:0] m, input int w, input bit again);
    drive(m, BASE, 12);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    drive(m, SPK, w);
    if (again)
    begin
      drive(m, BASE, 2);
      drive(m, SPK, 1);
    end
    drive(m, BASE, 30);
  endtask

  task automatic t_regs;
    rdchk(OFF_WIN, 32'h0, 1'b0);
    wr(OFF_WIN, WIN);
    wr(OFF_CFG3, CFG3);
    for (int c = 0; c < NCH; c++)
      wr(8'h40 + 8'(4*c), {20'h0, PED});
    rdchk(OFF_WIN, WIN, 1'b0);
    rdchk(8'h54, {20'h0, PED}, 1'b0);
    rdchk(8'h30, 32'h0, 1'b1);
  endtask

  task automatic t_single(input logic [NCH-1:0] m);
    int n;
    n = $countones(m);
    pulse(m, 1, 1'b0);
    chk(nz, 32'(BEF + AFT + 1), 1'b0);
    chk(total, 32'(n * ((BEF + AFT + 1) * (BASE - PED) + SPK - BASE)), 1'b0);
    chk(hits, 32'(n), 1'b0);
  endtask

  task automatic t_long_and_again;
    pulse(16'h0001, AFT + 4, 1'b0);
    chk(hits, 32'(AFT + 4), 1'b0);
    chk(nz, 32'(BEF + AFT + 5), 1'b1);
    pulse(16'h0001, 1, 1'b1);
    chk(hits, 32'h2, 1'b0);
    chk(nz, 32'(BEF + AFT + 3), 1'b1);
  endtask

  task automatic t_sync_status;
    wr(OFF_CFG1, 32'h0000_0300);
    drive(16'h0008, 12'h2ab, 8);
    rdchk(OFF_STAT, 32'h0000_02ab, 1'b0);
    wr(OFF_CTRL, 32'h4);
    @(posedge pclk);
    sync_in <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(OFF_STAT, 32'h0000_02ab, 1'b0);
    sync_in <= 1'b0;
    apb(1'b0, OFF_TSTAMP, 32'h0);
    chk(32'd40, rd, 1'b1);
    chk({31'h0, converter_reset}, 32'h1, 1'b0);
    wr(OFF_CTRL, 32'h0);
    @(negedge pclk);
    chk({31'h0, converter_reset}, 32'h0, 1'b0);
  endtask

  task automatic t_resets;
    wr(OFF_CTRL, 32'h1);
    rdchk(OFF_WIN, WIN, 1'b0);
    rdchk(OFF_CFG3, CFG3, 1'b0);
    t_single(16'h0001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({16'h0, energy_sum}, 32'h0, 1'b0);
    presetn <= 1'b1;
    rdchk(OFF_WIN, 32'h0, 1'b0);
    rdchk(8'h40, 32'h0, 1'b0);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    adc_data = '0;
    sync_in = 1'b0;
    clr = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_single(16'h0001);
    t_single(16'hffff);
    t_long_and_again();
    t_sync_status();
    t_resets();
    wrap_up();
  end
endmodule
`default_nettype wire
